// ---- bench/register_host_model.sv ----
`default_nettype none
`include "sensor_batching_fifo_consts.svh"
module register_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_reg_rdata,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
  end

  // one access; address and data inverted when idle, strobes low, so stale values never pass
  task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic is_wr,
                        output logic [7:0] rdata);
    @(posedge i_clk_sys);
    #1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    o_reg_wr = is_wr;
    o_reg_rd = !is_wr;
    @(posedge i_clk_sys);
    #1;
    rdata = i_reg_rdata;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = ~addr;
    o_reg_wdata = ~data;
  endtask : access

  // low byte first, high byte completes the word
  task automatic read_word(output logic [15:0] word);
    logic [7:0] lo;
    logic [7:0] hi;
    access(`ADDR_DATA_LOW, 8'h00, 1'b0, lo);
    access(`ADDR_DATA_HIGH, 8'h00, 1'b0, hi);
    word = {hi, lo};
  endtask : read_word
endmodule : register_host_model
`default_nettype wire

// ---- bench/sensor_batching_fifo_tb.sv ----
`default_nettype none
`include "sensor_batching_fifo_consts.svh"
`define CHECK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module sensor_batching_fifo_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [47:0] gyro = 48'h0000_0000_0000;
  logic [47:0] accel = 48'h0000_0000_0000;
  logic [95:0] hub = 96'h0000_0000_0000_0000_0000_0000;
  logic [47:0] step_time = 48'h0000_0000_0000;
  logic [47:0] temp = 48'h0000_0000_0000;
  logic motion = 1'b0;
  logic hub_done = 1'b0;
  logic step = 1'b0;
  logic hub_sel = 1'b0;
  logic mode_trig = 1'b1;
  logic [5:0] routes = 6'h00;
  logic irq1;
  logic irq2;
  logic [31:0] seed = 32'h0000_0027;
  int errors = 0;
  int tests_run = 0;
  logic [7:0] ctl_addr [5] = '{`ADDR_THRESHOLD_LOW, `ADDR_THRESHOLD_HIGH, `ADDR_MOTION_DECIMATION,
                               `ADDR_AUX_DECIMATION, `ADDR_MODE};
  logic [7:0] ctl_mask [5] = '{8'hFF, 8'hCF, 8'h3F, 8'hFF, 8'h07};
  logic [5:0] factor [8] = '{6'h03, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h10, 6'h20};

  initial begin
    forever #50 clk = ~clk;
  end

  register_host_model host (.i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd));

  sensor_batching_fifo #(.DEPTH(16), .LEVEL_W(4)) dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_gyro_data(gyro), .i_accel_data(accel), .i_hub_result_byte_first(hub),
    .i_step_time_data(step_time), .i_temp_data(temp), .i_motion_data_ready(motion),
    .i_hub_operation_done(hub_done), .i_step_detected(step), .i_hub_trigger_select(hub_sel),
    .i_mode_trigger(mode_trig), .i_line_one_full_route(routes[0]), .i_line_one_threshold_route(routes[1]),
    .i_line_one_overrun_route(routes[2]), .i_line_two_full_route(routes[3]),
    .i_line_two_threshold_route(routes[4]), .i_line_two_overrun_route(routes[5]),
    .o_interrupt_line_one(irq1), .o_interrupt_line_two(irq2));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [47:0] r48();
    return 48'({rnd(), rnd()});
  endfunction : r48

  // high-only slot one: accel and gyro upper bytes per axis
  function automatic logic [47:0] high_pack(input logic [47:0] g, input logic [47:0] a);
    return {a[47:40], g[47:40], a[31:24], g[31:24], a[15:8], g[15:8]};
  endfunction : high_pack

  task automatic report_and_stop();
    $display("checks made %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.access(a, d, 1'b1, unused);
  endtask : put

  task automatic check_reg(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp,
                           input string what);
    logic [7:0] v;
    host.access(a, 8'h00, 1'b0, v);
    `CHECK(what, exp, v & mask)
  endtask : check_reg

  // bypass flushes, then the wanted mode
  task automatic restart(input logic [2:0] mode);
    put(`ADDR_MODE, 8'h00);
    put(`ADDR_MODE, {5'h00, mode});
  endtask : restart

  // kind 0 motion, 1 hub done, 2 step; fresh random sets each time
  task automatic fire(input int kind);
    @(posedge clk);
    #1;
    gyro = r48();
    accel = r48();
    hub = {r48(), r48()};
    step_time = r48();
    temp = r48();
    motion = (kind == 0);
    hub_done = (kind == 1);
    step = (kind == 2);
    @(posedge clk);
    #1;
    motion = 1'b0;
    hub_done = 1'b0;
    step = 1'b0;
    repeat (13) @(posedge clk);
  endtask : fire

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    logic [15:0] w16;
    logic [47:0] sets [4];
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      check_reg(ctl_addr[i], 8'hFF, 8'h00, "reset value");
      put(ctl_addr[i], 8'hFF);
      check_reg(ctl_addr[i], 8'hFF, ctl_mask[i], "writable bits");
    end
    check_reg(8'h20, 8'hFF, 8'h00, "unmapped");
    check_reg(`ADDR_STATUS, 8'hFF, 8'h10, "empty status");
    $display("test registers done");
    put(`ADDR_THRESHOLD_HIGH, 8'h08);
    put(`ADDR_MOTION_DECIMATION, 8'h09);
    put(`ADDR_AUX_DECIMATION, 8'h09);
    restart(`MODE_STOP_FULL);
    fire(0);
    sets = '{gyro, accel, hub[47:0], temp};
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h0C, "words stored");
    for (int s = 0; s < 4; s++) begin
      for (int w = 0; w < 3; w++) begin
        host.read_word(w16);
        `CHECK("buffer word", sets[s][16*w +: 16], w16)
      end
    end
    check_reg(`ADDR_STATUS, 8'hFF, 8'h10, "drained");
    $display("test data order done");
    put(`ADDR_AUX_DECIMATION, 8'h48);
    put(`ADDR_THRESHOLD_HIGH, 8'h80);
    restart(`MODE_STOP_FULL);
    fire(0);
    sets = '{high_pack(gyro, accel), step_time, 48'h0000_0000_0000, 48'h0000_0000_0000};
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h06, "high only words");
    for (int i = 0; i < 6; i++) begin
      host.read_word(w16);
      `CHECK("high only word", sets[i / 3][16 * (i % 3) +: 16], w16)
    end
    $display("test high only done");
    put(`ADDR_THRESHOLD_HIGH, 8'h00);
    for (int c = 0; c < 8; c++) begin
      put(`ADDR_MOTION_DECIMATION, 8'(c));
      put(`ADDR_AUX_DECIMATION, 8'(c << 3));
      restart(`MODE_STOP_FULL);
      repeat (factor[c]) fire(0);
      check_reg(`ADDR_COUNT_LOW, 8'hFF, (c == 0) ? 8'h00 : 8'h06, "decimated");
    end
    $display("test decimation done");
    put(`ADDR_THRESHOLD_LOW, 8'h06);
    put(`ADDR_MOTION_DECIMATION, 8'h08);
    put(`ADDR_AUX_DECIMATION, 8'h00);
    routes = 6'h02;
    restart(`MODE_STOP_FULL);
    fire(0);
    check_reg(`ADDR_STATUS, 8'hFF, 8'h00, "below level");
    `CHECK("line one low", 1'b0, irq1)
    fire(0);
    check_reg(`ADDR_STATUS, 8'hFF, 8'h80, "at level");
    `CHECK("line one", 1'b1, irq1)
    `CHECK("line two", 1'b0, irq2)
    put(`ADDR_AUX_DECIMATION, 8'h80);
    fire(0);
    check_reg(`ADDR_STATUS, 8'hFF, 8'hA0, "depth limit");
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h06, "limited count");
    $display("test watermark done");
    routes = 6'h20;
    restart(`MODE_CONTINUOUS);
    repeat (6) fire(0);
    check_reg(`ADDR_STATUS, 8'h40, 8'h40, "overrun");
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h00, "overrun count");
    `CHECK("line two overrun", 1'b1, irq2)
    routes = 6'h09;
    restart(`MODE_STOP_FULL);
    repeat (6) fire(0);
    check_reg(`ADDR_STATUS, 8'h60, 8'h20, "full no overrun");
    `CHECK("line one full", 1'b1, irq1)
    `CHECK("line two full", 1'b1, irq2)
    restart(`MODE_BYPASS);
    fire(0);
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h00, "bypass");
    restart(`MODE_BYPASS_TO_CONT);
    fire(0);
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h00, "bypass before release");
    @(posedge clk);
    #1;
    mode_trig = 1'b0;
    repeat (3) fire(0);
    check_reg(`ADDR_STATUS, 8'h40, 8'h40, "continuous after release");
    @(posedge clk);
    #1;
    mode_trig = 1'b1;
    restart(`MODE_CONT_TO_STOP);
    repeat (3) fire(0);
    check_reg(`ADDR_STATUS, 8'h40, 8'h40, "continuous before release");
    host.read_word(w16);
    @(posedge clk);
    #1;
    mode_trig = 1'b0;
    fire(0);
    check_reg(`ADDR_STATUS, 8'h60, 8'h20, "stop after release");
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h06, "stop count");
    $display("test modes done");
    hub_sel = 1'b1;
    restart(`MODE_STOP_FULL);
    fire(0);
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h00, "motion ignored");
    fire(1);
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h03, "hub trigger");
    hub_sel = 1'b0;
    put(`ADDR_THRESHOLD_HIGH, 8'h40);
    fire(2);
    check_reg(`ADDR_COUNT_LOW, 8'hFF, 8'h06, "step trigger");
    $display("test triggers done");
    report_and_stop();
  end
endmodule : sensor_batching_fifo_tb
`default_nettype wire

// ---- rtl/sensor_batching_fifo.sv ----
`default_nettype none
`include "sensor_batching_fifo_consts.svh"
module sensor_batching_fifo #(
  parameter int DEPTH = 2048,
  parameter int LEVEL_W = 11
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [47:0] i_gyro_data,
  input wire logic [47:0] i_accel_data,
  input wire logic [95:0] i_hub_result_byte_first,
  input wire logic [47:0] i_step_time_data,
  input wire logic [47:0] i_temp_data,
  input wire logic i_motion_data_ready,
  input wire logic i_hub_operation_done,
  input wire logic i_step_detected,
  input wire logic i_hub_trigger_select,
  input wire logic i_mode_trigger,
  input wire logic i_line_one_full_route,
  input wire logic i_line_one_threshold_route,
  input wire logic i_line_one_overrun_route,
  input wire logic i_line_two_full_route,
  input wire logic i_line_two_threshold_route,
  input wire logic i_line_two_overrun_route,
  output logic o_interrupt_line_one,
  output logic o_interrupt_line_two
);
  localparam int CW = LEVEL_W + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  if (DEPTH < 16 || DEPTH != (1 << LEVEL_W)) begin : g_bad_depth
    $error("depth must be two to the power of the level width");
  end

  // control registers
  logic [7:0] threshold_low, threshold_high, motion_dec, aux_dec, mode_reg;
  logic [7:0] next_threshold_low, next_threshold_high, next_motion_dec, next_aux_dec, next_mode_reg;
  logic [LEVEL_W-1:0] watermark_level;
  logic stop_at_threshold, high_only, step_time_slot_enable, step_trigger_select, temp_enable;

  always_comb begin
    next_threshold_low = threshold_low;
    next_threshold_high = threshold_high;
    next_motion_dec = motion_dec;
    next_aux_dec = aux_dec;
    next_mode_reg = mode_reg;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `ADDR_THRESHOLD_LOW: next_threshold_low = i_reg_wdata;
        `ADDR_THRESHOLD_HIGH: next_threshold_high = i_reg_wdata & `MASK_THRESHOLD_HIGH;
        `ADDR_MOTION_DECIMATION: next_motion_dec = i_reg_wdata & `MASK_MOTION_DECIMATION;
        `ADDR_AUX_DECIMATION: next_aux_dec = i_reg_wdata;
        `ADDR_MODE: next_mode_reg = i_reg_wdata & `MASK_MODE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      threshold_low <= `REG_RESET;
      threshold_high <= `REG_RESET;
      motion_dec <= `REG_RESET;
      aux_dec <= `REG_RESET;
      mode_reg <= `REG_RESET;
    end else begin
      threshold_low <= next_threshold_low;
      threshold_high <= next_threshold_high;
      motion_dec <= next_motion_dec;
      aux_dec <= next_aux_dec;
      mode_reg <= next_mode_reg;
    end
  end

  assign watermark_level = LEVEL_W'({threshold_high[2:0], threshold_low});
  assign step_time_slot_enable = threshold_high[`BIT_STEP_TIME_ENABLE];
  assign step_trigger_select = threshold_high[`BIT_STEP_TRIGGER];
  assign temp_enable = threshold_high[`BIT_TEMP_ENABLE];
  assign stop_at_threshold = aux_dec[`BIT_STOP_AT_THRESHOLD];
  assign high_only = aux_dec[`BIT_HIGH_ONLY];

  // mode decode with trigger-driven switch-over
  logic switched, next_switched;
  sensor_batching_fifo_pkg::store_policy_t policy;

  always_comb begin
    next_switched = switched;
    if (!i_mode_trigger) begin
      next_switched = 1'b1;
    end else if (i_reg_wr && i_reg_addr == `ADDR_MODE) begin
      next_switched = 1'b0;
    end
    unique case (mode_reg[2:0])
      `MODE_STOP_FULL: policy = sensor_batching_fifo_pkg::policy_stop;
      `MODE_CONTINUOUS: policy = sensor_batching_fifo_pkg::policy_wrap;
      `MODE_CONT_TO_STOP: policy = switched ? sensor_batching_fifo_pkg::policy_stop
                                            : sensor_batching_fifo_pkg::policy_wrap;
      `MODE_BYPASS_TO_CONT: policy = switched ? sensor_batching_fifo_pkg::policy_wrap
                                              : sensor_batching_fifo_pkg::policy_off;
      default: policy = sensor_batching_fifo_pkg::policy_off;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      switched <= 1'b0;
    end else begin
      switched <= next_switched;
    end
  end

  // trigger selection and per-set decimation
  logic trigger, bypassing, busy;
  logic [3:0] due;
  logic [2:0] set_code [4];

  assign trigger = i_hub_trigger_select ? i_hub_operation_done
                 : (step_trigger_select ? i_step_detected : i_motion_data_ready);
  assign bypassing = (policy == sensor_batching_fifo_pkg::policy_off);
  assign set_code[0] = motion_dec[5:3];
  assign set_code[1] = motion_dec[2:0];
  assign set_code[2] = aux_dec[2:0];
  assign set_code[3] = aux_dec[5:3];

  for (genvar s = 0; s < `SET_COUNT; s++) begin : g_dec
    set_decimator u_dec (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_code(set_code[s]),
      .i_tick(trigger && !busy && !bypassing),
      .i_clear(bypassing),
      .o_due(due[s])
    );
  end

  // store sequencer: twelve word slots per trigger, in fixed set order
  sensor_batching_fifo_pkg::store_state_t state, next_state;
  logic [1:0] slot_set, next_slot_set, slot_word, next_slot_word;
  logic [3:0] due_q, next_due_q;
  logic [3:0][47:0] snap, next_snap;
  logic [47:0] packed_high;
  logic store_word;
  logic [15:0] store_data;

  assign busy = (state == sensor_batching_fifo_pkg::st_store);
  assign packed_high = {i_accel_data[47:40], i_gyro_data[47:40], i_accel_data[31:24],
                        i_gyro_data[31:24], i_accel_data[15:8], i_gyro_data[15:8]};

  always_comb begin
    next_state = state;
    next_slot_set = slot_set;
    next_slot_word = slot_word;
    next_due_q = due_q;
    next_snap = snap;
    unique case (state)
      sensor_batching_fifo_pkg::st_idle: begin
        if (trigger && !bypassing && due != 4'h0) begin
          next_state = sensor_batching_fifo_pkg::st_store;
          next_slot_set = 2'h0;
          next_slot_word = 2'h0;
          next_due_q = {due[3:2], due[1] && !high_only, due[0]};
          next_snap[0] = high_only ? packed_high : i_gyro_data;
          next_snap[1] = i_accel_data;
          next_snap[2] = i_hub_result_byte_first[47:0];
          next_snap[3] = step_time_slot_enable ? i_step_time_data
                       : (temp_enable ? i_temp_data : i_hub_result_byte_first[95:48]);
        end
      end
      sensor_batching_fifo_pkg::st_store: begin
        if (slot_word == 2'(`WORDS_PER_SET - 1)) begin
          next_slot_word = 2'h0;
          next_slot_set = slot_set + 2'h1;
          if (slot_set == 2'(`SET_COUNT - 1)) begin
            next_state = sensor_batching_fifo_pkg::st_idle;
          end
        end else begin
          next_slot_word = slot_word + 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= sensor_batching_fifo_pkg::st_idle;
      slot_set <= 2'h0;
      slot_word <= 2'h0;
      due_q <= 4'h0;
      snap <= '0;
    end else begin
      state <= next_state;
      slot_set <= next_slot_set;
      slot_word <= next_slot_word;
      due_q <= next_due_q;
      snap <= next_snap;
    end
  end

  assign store_word = busy && due_q[slot_set];
  assign store_data = snap[slot_set][{slot_word, 4'h0} +: 16];

  // word storage and occupancy
  logic [15:0] mem [DEPTH];
  logic [LEVEL_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count, limit;
  logic overrun, next_overrun;
  logic full, empty, watermark_reached_flag, read_pop, accept, overwrite;
  logic [10:0] unread_word_count;

  assign limit = stop_at_threshold ? {1'b0, watermark_level} : DEPTH_C;
  assign full = (count >= limit);
  assign empty = (count == '0);
  assign watermark_reached_flag = (count >= {1'b0, watermark_level});
  assign read_pop = i_reg_rd && (i_reg_addr == `ADDR_DATA_HIGH) && !empty;
  assign overwrite = store_word && (policy == sensor_batching_fifo_pkg::policy_wrap) && full && !read_pop;
  assign accept = store_word && !bypassing
                && (!full || read_pop || policy == sensor_batching_fifo_pkg::policy_wrap);
  assign unread_word_count = overrun ? 11'h000
                           : ((count > CW'(11'h7FF)) ? 11'h7FF : 11'(count));

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_overrun = overrun;
    if (bypassing) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
      next_overrun = 1'b0;
    end else begin
      next_wr_ptr = wr_ptr + LEVEL_W'(accept);
      next_rd_ptr = rd_ptr + LEVEL_W'(read_pop || overwrite);
      next_count = count + CW'(accept && !overwrite) - CW'(read_pop);
      if (overwrite) begin
        next_overrun = 1'b1;
      end else if (read_pop) begin
        next_overrun = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      overrun <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      overrun <= next_overrun;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (accept) begin
      mem[wr_ptr] <= store_data;
    end
  end

  // register read-back and interrupt lines
  logic [7:0] next_rdata;
  logic next_line_one, next_line_two;

  always_comb begin
    next_rdata = 8'h00;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `ADDR_THRESHOLD_LOW: next_rdata = threshold_low;
        `ADDR_THRESHOLD_HIGH: next_rdata = threshold_high;
        `ADDR_MOTION_DECIMATION: next_rdata = motion_dec;
        `ADDR_AUX_DECIMATION: next_rdata = aux_dec;
        `ADDR_MODE: next_rdata = mode_reg;
        `ADDR_COUNT_LOW: next_rdata = unread_word_count[7:0];
        `ADDR_STATUS: next_rdata = {watermark_reached_flag, overrun, full, empty, 1'b0, unread_word_count[10:8]};
        `ADDR_DATA_LOW: next_rdata = empty ? 8'h00 : mem[rd_ptr][7:0];
        `ADDR_DATA_HIGH: next_rdata = empty ? 8'h00 : mem[rd_ptr][15:8];
        default: next_rdata = 8'h00;
      endcase
    end
    next_line_one = (full && i_line_one_full_route) || (watermark_reached_flag && i_line_one_threshold_route)
                  || (overrun && i_line_one_overrun_route);
    next_line_two = (full && i_line_two_full_route) || (watermark_reached_flag && i_line_two_threshold_route)
                  || (overrun && i_line_two_overrun_route);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
      o_interrupt_line_one <= 1'b0;
      o_interrupt_line_two <= 1'b0;
    end else begin
      o_reg_rdata <= next_rdata;
      o_interrupt_line_one <= next_line_one;
      o_interrupt_line_two <= next_line_two;
    end
  end

  property p_bypass_flushes;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    bypassing |=> (count == '0) && !overrun;
  endproperty
  a_bypass_flushes: assert property (p_bypass_flushes) else $error("bypass left words stored");

  property p_stop_when_full;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (policy == sensor_batching_fifo_pkg::policy_stop && full && store_word && !read_pop) |=> (count == $past(count));
  endproperty
  a_stop_when_full: assert property (p_stop_when_full) else $error("stop mode grew past full");

  property p_write_counts_up;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (store_word && !bypassing && !full && !read_pop) |=> (count == $past(count) + CW'(1));
  endproperty
  a_write_counts_up: assert property (p_write_counts_up) else $error("stored word not counted");

  property p_read_counts_down;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (read_pop && !store_word && !bypassing) |=> (count == $past(count) - CW'(1));
  endproperty
  a_read_counts_down: assert property (p_read_counts_down) else $error("read word not removed");

  property p_overrun_hides_count;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    overwrite |=> overrun && (unread_word_count == '0);
  endproperty
  a_overrun_hides_count: assert property (p_overrun_hides_count) else $error("overrun did not zero count");

  property p_store_burst;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(busy) |-> busy [*8];
  endproperty
  a_store_burst: assert property (p_store_burst) else $error("store burst ended early");

  property p_watermark_rise;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == `ADDR_STATUS && count >= {1'b0, watermark_level}) |=> o_reg_rdata[7];
  endproperty
  a_watermark_rise: assert property (p_watermark_rise) else $error("watermark not reported");

  property p_depth_limit;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (stop_at_threshold && policy == sensor_batching_fifo_pkg::policy_stop && count <= limit) |=>
      (count <= $past(limit));
  endproperty
  a_depth_limit: assert property (p_depth_limit) else $error("depth passed threshold limit");

  property p_line_one_full;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (full && i_line_one_full_route) |=> o_interrupt_line_one;
  endproperty
  a_line_one_full: assert property (p_line_one_full) else $error("full not routed to line one");
endmodule : sensor_batching_fifo
`default_nettype wire

// ---- rtl/sensor_batching_fifo_consts.svh ----
`ifndef SENSOR_BATCHING_FIFO_CONSTS_SVH
`define SENSOR_BATCHING_FIFO_CONSTS_SVH

// register offsets
`define ADDR_THRESHOLD_LOW 8'h06
`define ADDR_THRESHOLD_HIGH 8'h07
`define ADDR_MOTION_DECIMATION 8'h08
`define ADDR_AUX_DECIMATION 8'h09
`define ADDR_MODE 8'h0A
`define ADDR_COUNT_LOW 8'h3A
`define ADDR_STATUS 8'h3B
`define ADDR_DATA_LOW 8'h40
`define ADDR_DATA_HIGH 8'h41

// reset value and write masks
`define REG_RESET 8'h00
`define MASK_THRESHOLD_HIGH 8'hCF
`define MASK_MOTION_DECIMATION 8'h3F
`define MASK_MODE 8'h07

// field positions
`define BIT_STEP_TIME_ENABLE 7
`define BIT_STEP_TRIGGER 6
`define BIT_TEMP_ENABLE 3
`define BIT_STOP_AT_THRESHOLD 7
`define BIT_HIGH_ONLY 6

// mode codes
`define MODE_BYPASS 3'b000
`define MODE_STOP_FULL 3'b001
`define MODE_CONT_TO_STOP 3'b011
`define MODE_BYPASS_TO_CONT 3'b100
`define MODE_CONTINUOUS 3'b110

// data set geometry
`define SET_COUNT 4
`define WORDS_PER_SET 3
`define SET_BITS 48

`endif

// ---- rtl/sensor_batching_fifo_pkg.sv ----
`default_nettype none
package sensor_batching_fifo_pkg;
  typedef enum logic [1:0] {policy_off, policy_stop, policy_wrap} store_policy_t;
  typedef enum logic {st_idle, st_store} store_state_t;
endpackage : sensor_batching_fifo_pkg
`default_nettype wire

// ---- rtl/set_decimator.sv ----
`default_nettype none
module set_decimator (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [2:0] i_code,
  input wire logic i_tick,
  input wire logic i_clear,
  output logic o_due
);
  logic [4:0] phase;
  logic [4:0] next_phase;
  logic [4:0] last;

  // code to last phase of the period
  function automatic logic [4:0] period_last(input logic [2:0] code);
    unique case (code)
      3'b000, 3'b001: period_last = 5'h00;
      3'b010: period_last = 5'h01;
      3'b011: period_last = 5'h02;
      3'b100: period_last = 5'h03;
      3'b101: period_last = 5'h07;
      3'b110: period_last = 5'h0F;
      3'b111: period_last = 5'h1F;
    endcase
  endfunction : period_last

  assign last = period_last(i_code);
  // set is written only on rollover
  assign o_due = i_tick && (i_code != 3'b000) && (phase >= last);

  always_comb begin
    next_phase = phase;
    if (i_clear || i_code == 3'b000) begin
      next_phase = 5'h00;
    end else if (i_tick) begin
      next_phase = (phase >= last) ? 5'h00 : phase + 5'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      phase <= 5'h00;
    end else begin
      phase <= next_phase;
    end
  end

  property p_excluded_never_due;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_code == 3'b000) |-> !o_due;
  endproperty
  a_excluded_never_due: assert property (p_excluded_never_due) else $error("excluded set was due");

  property p_factor_two;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_tick && i_code == 3'b010 && !i_clear && phase <= 5'h01) |-> (o_due == phase[0]);
  endproperty
  a_factor_two: assert property (p_factor_two) else $error("factor two set due off its turn");
endmodule : set_decimator
`default_nettype wire
